// ==== rtl/direct_mapped_instruction_cache.sv ====
// Direct-mapped instruction cache with forced-access array window.
// Assumes the external bus controller answers fills with fill_ack and data.
`timescale 1ns/1ps
`default_nettype none

module direct_mapped_instruction_cache
  import icache_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          power_on_reset,
  input  wire logic          enable_write,
  input  wire logic [4:0]    enable_wdata,
  output logic      [4:0]    cache_space_enable,
  input  wire logic          ras_down_mode,
  input  wire core_req_type  core_req,
  output logic               core_ready,
  output logic      [31:0]   core_rdata,
  output logic               core_hit,
  output fill_req_type       fill_req,
  input  wire logic          fill_ack,
  input  wire logic [31:0]   fill_rdata,
  output logic               next_cycle_delay
);

  // ************************************************************
  // Storage
  // ************************************************************
  tag_entry_type         tag_mem [ENTRIES];
  logic [31:0]           data_mem [ENTRIES];
  logic [4:0]            cache_space_enable_reg;
  cache_state_type       state_reg;
  logic                  prev_miss_reg;
  logic                  after_miss_reg;
  logic [31:0]           rdata_reg;
  logic                  hit_reg;
  logic                  delay_reg;
  logic [31:0]           fill_addr_reg;
  logic                  fill_dram_reg;

  // ************************************************************
  // Decode
  // ************************************************************
  logic                  in_tag_win;
  logic                  in_data_win;
  logic                  in_cs;
  logic                  in_dram;
  logic                  space_on;
  logic                  any_enable;
  logic                  cacheable;
  logic [INDEX_W-1:0]    index;
  logic [TAG_W-1:0]      tag;
  logic                  lookup_hit;
  logic                  idle;
  logic                  start_fill;
  logic                  true_hit;
  logic                  fill_done;
  logic                  window_write;
  logic                  window_read;
  logic [INDEX_W-1:0]    fill_index;
  logic [TAG_W-1:0]      fill_tag;
  logic [31:0]           tag_word;
  tag_entry_type         tag_wentry;

  assign index       = core_req.addr[INDEX_LSB +: INDEX_W];
  assign tag         = core_req.addr[TAG_LSB +: TAG_W];
  assign in_tag_win  = core_req.addr >= TAG_WIN_BASE && core_req.addr < DATA_WIN_BASE;
  assign in_data_win = core_req.addr >= DATA_WIN_BASE && core_req.addr <= DATA_WIN_LAST;
  assign in_cs       = core_req.addr <= CS_LAST;
  assign in_dram     = core_req.addr >= DRAM_BASE && core_req.addr <= DRAM_LAST;
  assign any_enable  = |cache_space_enable_reg;
  assign lookup_hit  = tag_mem[index].valid && tag_mem[index].tag == tag;
  assign idle        = state_reg == ST_IDLE;

  // Chip-select number comes from the two address bits above the 4 MB span
  always_comb begin
    space_on = 1'b0;
    if (in_dram) begin
      space_on = cache_space_enable_reg[DRAM_EN_BIT];
    end else if (in_cs) begin
      space_on = cache_space_enable_reg[core_req.addr[SEL_LSB +: 2]];
    end
  end

  // Writes and plain data reads never allocate; only fetch-type reads do
  always_comb begin
    cacheable = 1'b0;
    if (core_req.req && !core_req.we && core_req.cacheable_kind) begin
      cacheable = (in_cs || in_dram) && space_on;
    end
  end

  // ************************************************************
  // Lookup outcome
  // ************************************************************
  assign start_fill   = idle && cacheable && (!lookup_hit || after_miss_reg);
  assign true_hit     = idle && cacheable && lookup_hit && !after_miss_reg;
  assign fill_done    = state_reg == ST_FILL && fill_ack;
  assign fill_index   = fill_addr_reg[INDEX_LSB +: INDEX_W];
  assign fill_tag     = fill_addr_reg[TAG_LSB +: TAG_W];

  // ************************************************************
  // Window access
  // ************************************************************
  // Any set enable bit locks the window against writes
  assign window_write = idle && core_req.req && core_req.we && !any_enable;
  assign window_read  = idle && core_req.req && !core_req.we;

  // Tag word layout: valid on top, tag at its address position, rest zero
  always_comb begin
    tag_word                   = 32'h00000000;
    tag_word[VALID_BIT]        = tag_mem[index].valid;
    tag_word[TAG_LSB +: TAG_W] = tag_mem[index].tag;
  end

  always_comb begin
    tag_wentry.valid = core_req.wdata[VALID_BIT];
    tag_wentry.tag   = core_req.wdata[TAG_LSB +: TAG_W];
  end

  // ************************************************************
  // Enable register
  // ************************************************************
  // Only power-on reset clears it; sys_rst alone models a manual reset.
  always_ff @(posedge ref_clk) begin
    if (power_on_reset) begin
      cache_space_enable_reg <= ENABLE_RESET;
    end else if (enable_write) begin
      cache_space_enable_reg <= enable_wdata;
    end
  end

  assign cache_space_enable = cache_space_enable_reg;

  // ************************************************************
  // Lookup and fill sequencing
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_fill) begin
            // Consecutive misses and the post-miss hit skip the idle cycle
            if (prev_miss_reg) begin
              state_reg <= ST_FILL;
            end else begin
              state_reg <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          state_reg <= ST_FILL;
        end
        ST_FILL: begin
          if (fill_ack) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Address and space stay frozen for the whole external transfer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fill_addr_reg <= 32'h00000000;
      fill_dram_reg <= 1'b0;
    end else if (start_fill) begin
      fill_addr_reg <= core_req.addr;
      fill_dram_reg <= in_dram;
    end
  end

  // ************************************************************
  // Miss history
  // ************************************************************
  // Any fill start makes the next miss back to back; other accesses break the run
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_miss_reg <= 1'b0;
    end else if (start_fill) begin
      prev_miss_reg <= 1'b1;
    end else if (idle && core_req.req) begin
      prev_miss_reg <= 1'b0;
    end
  end

  // A miss marks the next hit as post-miss and its refill clears the mark;
  // without the clear a held request would be refilled for ever
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      after_miss_reg <= 1'b0;
    end else if (start_fill) begin
      after_miss_reg <= !lookup_hit;
    end
  end

  // ************************************************************
  // Arrays: fills and forced access
  // ************************************************************
  // A fill needs FILL and a window access needs IDLE, so they never collide
  always_ff @(posedge ref_clk) begin
    if (fill_done) begin
      tag_mem[fill_index] <= '{valid: 1'b1, tag: fill_tag};
    end else if (window_write && in_tag_win) begin
      tag_mem[index] <= tag_wentry;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (fill_done) begin
      data_mem[fill_index] <= fill_rdata;
    end else if (window_write && in_data_win) begin
      data_mem[index] <= core_req.wdata;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // While enabled, window reads simply return the array contents
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h00000000;
    end else if (fill_done) begin
      rdata_reg <= fill_rdata;
    end else if (window_read && in_tag_win) begin
      rdata_reg <= tag_word;
    end else if (window_read && in_data_win) begin
      rdata_reg <= data_mem[index];
    end else if (true_hit) begin
      rdata_reg <= data_mem[index];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= true_hit;
    end
  end

  // ************************************************************
  // Bus timing controls
  // ************************************************************
  // Only a DRAM fill in row-strobe-down mode pushes the next cycle back
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      delay_reg <= 1'b0;
    end else begin
      delay_reg <= fill_done && fill_dram_reg && ras_down_mode;
    end
  end

  always_comb begin
    fill_req            = '0;
    fill_req.req        = state_reg == ST_FILL;
    fill_req.dram       = fill_dram_reg;
    fill_req.cs_extend  = state_reg == ST_FILL && !fill_dram_reg;
    fill_req.ras_extend = state_reg == ST_FILL && fill_dram_reg;
    fill_req.addr       = fill_addr_reg;
  end
  assign next_cycle_delay    = delay_reg;

  // ************************************************************
  // Core answer
  // ************************************************************
  // Non-cacheable, non-window requests are for other slaves; answered at once
  assign core_ready = idle && core_req.req && !start_fill;
  assign core_rdata = rdata_reg;
  assign core_hit   = hit_reg;

endmodule

`default_nettype wire

// ==== rtl/icache_pkg.sv ====
// Constants and carrier types for the direct-mapped instruction cache.
// Assumes a 32-bit byte address space and a single synchronous clock domain.
package icache_pkg;

  localparam logic [31:0] TAG_WIN_BASE   = 32'hfffff000;
  localparam logic [31:0] DATA_WIN_BASE  = 32'hfffff400;
  localparam logic [31:0] DATA_WIN_LAST  = 32'hfffff7ff;
  localparam logic [31:0] CS0_BASE       = 32'h00000000;
  localparam logic [31:0] CS_LAST        = 32'h00ffffff;
  localparam logic [31:0] DRAM_BASE      = 32'h01000000;
  localparam logic [31:0] DRAM_LAST      = 32'h01ffffff;
  localparam int          ENTRIES        = 256;
  localparam int          INDEX_W        = 8;
  localparam int          INDEX_LSB      = 2;
  localparam int          TAG_W          = 15;
  localparam int          TAG_LSB        = 10;
  localparam int          VALID_BIT      = 31;
  localparam int          SEL_LSB        = 22;
  localparam int          DRAM_EN_BIT    = 4;
  localparam logic [4:0]  ENABLE_RESET   = 5'h00;

  typedef struct packed {
    logic        valid;
    logic [14:0] tag;
  } tag_entry_type;

  // Request from the core side
  typedef struct packed {
    logic        req;
    logic        we;
    logic        cacheable_kind;
    logic [31:0] addr;
    logic [31:0] wdata;
  } core_req_type;

  // Fill request toward the external bus controller
  typedef struct packed {
    logic        req;
    logic        dram;
    logic        cs_extend;
    logic        ras_extend;
    logic [31:0] addr;
  } fill_req_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GAP  = 2'b01,
    ST_FILL = 2'b11,
    ST_DONE = 2'b10
  } cache_state_type;

endpackage

// ==== sim/icache_checker.sv ====
// Concurrent checks on the cache fill and enable ports.
// Assumes binding into direct_mapped_instruction_cache.
`timescale 1ns/1ps
`default_nettype none
module icache_checker
  import icache_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         sys_rst,
  input wire logic         power_on_reset,
  input wire logic         enable_write,
  input wire logic [4:0]   enable_wdata,
  input wire logic [4:0]   cache_space_enable,
  input wire logic         ras_down_mode,
  input wire logic         core_hit,
  input wire fill_req_type fill_req,
  input wire logic         fill_ack,
  input wire logic         next_cycle_delay
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  cs_extend_a: assert property (fill_req.req |-> fill_req.cs_extend == !fill_req.dram)
    else $error("chip select extension wrong");
  ras_extend_a: assert property (fill_req.req |-> fill_req.ras_extend == fill_req.dram)
    else $error("row strobe extension wrong");
  fill_hold_a: assert property (fill_req.req && !fill_ack |=> fill_req.req && $stable(fill_req))
    else $error("fill request changed while waiting");
  fill_end_a: assert property (fill_req.req && fill_ack |=> !fill_req.req)
    else $error("fill request stayed after ack");
  ras_delay_a: assert property (fill_req.req && fill_req.dram && fill_ack |=> next_cycle_delay == $past(ras_down_mode))
    else $error("next cycle delay wrong");
  quiet_reset_a: assert property ($fell(sys_rst) |-> !fill_req.req && !core_hit)
    else $error("outputs active after reset");
  enable_load_a: assert property (enable_write && !power_on_reset |=> cache_space_enable == $past(enable_wdata))
    else $error("enable load wrong");
  enable_hold_a: assert property (!enable_write && !power_on_reset |=> $stable(cache_space_enable))
    else $error("enables changed unasked");
  por_clear_a: assert property (power_on_reset |=> cache_space_enable == ENABLE_RESET)
    else $error("enables not cleared");
  hit_quiet_a: assert property (core_hit |-> !fill_req.req)
    else $error("fill during true hit");
endmodule
bind direct_mapped_instruction_cache icache_checker icache_checker_i (.*);
`default_nettype wire

// ==== sim/fill_partner.sv ====
// Bus controller stand-in answering line fills, alternately prompt and slow.
// Assumes fill requests stay up until acknowledged.
`timescale 1ns/1ps
`default_nettype none
module fill_partner
  import icache_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire fill_req_type fill_req,
  output logic              fill_ack,
  output logic [31:0]       fill_rdata
);
  logic slow_reg = 1'b0;
  logic wait_reg = 1'b0;
  // Data is only meaningful with the ack pulse; otherwise it churns
  always @(posedge ref_clk) begin
    fill_ack <= 1'b0;
    fill_rdata <= ~fill_rdata;
    if (fill_req.req && !fill_ack) begin
      if (slow_reg && !wait_reg) begin
        wait_reg <= 1'b1;
      end else begin
        fill_ack <= 1'b1;
        fill_rdata <= {fill_req.addr[15:0], ~fill_req.addr[31:16]};
        slow_reg <= ~slow_reg;
        wait_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_direct_mapped_instruction_cache.sv ====
// Self-checking bench for the instruction cache with a reference model.
// Assumes fill_partner answers fills with the line pattern used below.
`timescale 1ns/1ps
`default_nettype none
module tb_direct_mapped_instruction_cache
  import icache_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         power_on_reset = 1'b1;
  logic         enable_write = 1'b0;
  logic [4:0]   enable_wdata = 5'h00;
  logic         ras_down_mode = 1'b0;
  core_req_type core_req = '0;
  logic [4:0]   cache_space_enable;
  logic         core_ready, core_hit, next_cycle_delay, fill_ack, hits;
  logic [31:0]  core_rdata, fill_rdata, rd, r, a;
  fill_req_type fill_req;
  logic [31:0]  tag_m [256];
  logic [31:0]  data_m [256];
  int           failures = 0, checks_done = 0, fills, gaps, delays, idx, seed = 32'hb787;
  always #2 ref_clk = ~ref_clk;
  direct_mapped_instruction_cache direct_mapped_instruction_cache_i (.*);
  fill_partner fill_partner_i (.*);
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task access(logic we, logic kind, logic [31:0] ad, logic [31:0] wd);
    int n;
    n = 0;
    fills = 0;
    gaps = 0;
    delays = 0;
    core_req <= '{1'b1, we, kind, ad, wd};
    do begin
      @(posedge ref_clk);
      n++;
      if (fill_req.req === 1'b1 && fill_ack === 1'b1) fills++;
      if (fills == 0 && fill_req.req !== 1'b1) gaps++;
      if (next_cycle_delay === 1'b1) delays++;
    end while (core_ready !== 1'b1 && n < 200);
    check("request taken", core_ready, 1'b1);
    core_req.req <= 1'b0;
    @(posedge ref_clk);
    rd = core_rdata;
    hits = core_hit;
    if (next_cycle_delay === 1'b1) delays++;
  endtask
  task set_enable(logic [4:0] v);
    enable_write <= 1'b1;
    enable_wdata <= v;
    @(posedge ref_clk);
    enable_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Model of a fill: line pattern of the partner, tag word with valid set
  task fetch(logic [31:0] ad, int exp_fills);
    access(1'b0, 1'b1, ad, 32'h0);
    data_m[ad[9:2]] = {ad[15:0], ~ad[31:16]};
    tag_m[ad[9:2]] = {1'b1, 6'h00, ad[24:10], 10'h000};
    check("fill count", fills, exp_fills);
    check("line data", rd, data_m[ad[9:2]]);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    power_on_reset <= 1'b0;
    @(posedge ref_clk);
    check("enable reset", cache_space_enable, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      idx = (i * 37) % 256;
      access(1'b1, 1'b0, TAG_WIN_BASE + idx * 4, r);
      access(1'b1, 1'b0, DATA_WIN_BASE + idx * 4, ~r);
      tag_m[idx] = {r[31], 6'h00, r[24:10], 10'h000};
      data_m[idx] = ~r;
      access(1'b0, 1'b0, TAG_WIN_BASE + idx * 4, 32'h0);
      check("tag read", rd, tag_m[idx]);
      access(1'b0, 1'b0, DATA_WIN_BASE + idx * 4, 32'h0);
      check("data read", rd, data_m[idx]);
    end
    access(1'b1, 1'b0, DATA_WIN_LAST - 3, r);
    access(1'b0, 1'b0, DATA_WIN_LAST - 3, 32'h0);
    check("last line", rd, r);
    for (int i = 0; i < ENTRIES; i++) begin
      access(1'b1, 1'b0, TAG_WIN_BASE + i * 4, 32'h0);
      tag_m[i] = 32'h0;
    end
    $display("test forced access done");
    set_enable(5'h01);
    access(1'b1, 1'b0, DATA_WIN_BASE, 32'h0);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check("enable kept", cache_space_enable, 32'h1);
    power_on_reset <= 1'b1;
    @(posedge ref_clk);
    power_on_reset <= 1'b0;
    @(posedge ref_clk);
    check("enable cleared", cache_space_enable, 32'h0);
    access(1'b0, 1'b0, DATA_WIN_BASE, 32'h0);
    check("write ignored", rd, data_m[0]);
    $display("test enable and ignore done");
    set_enable(5'h1f);
    ras_down_mode <= 1'b1;
    a = 32'h00400100 | ($random(seed) & 32'h003ffc00);
    fetch(a, 2);
    check("idle before fill", gaps, 2);
    access(1'b0, 1'b1, a, 32'h0);
    check("true hit", hits, 1);
    check("hit no fill", fills, 0);
    check("hit data", rd, data_m[a[9:2]]);
    fetch(a + 32'h400, 2);
    fetch(32'h01000204, 2);
    check("next cycle delay", delays > 0, 1);
    set_enable(5'h1e);
    for (int k = 0; k < 2; k++) begin
      repeat (2) access(1'b0, k[0], 32'h00000500, 32'h0);
      check("no hit uncached", hits, 0);
    end
    set_enable(5'h00);
    a = a + 32'h400;
    access(1'b0, 1'b0, TAG_WIN_BASE + a[9:2] * 4, 32'h0);
    check("filled tag", rd, tag_m[a[9:2]]);
    $display("test fill and hit done");
    final_report;
  end
  initial begin
    #200000;
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
